// [verification/sdram_link_asserts.sv]
`timescale 1ns/1ps
// protocol checks on the controller-memory pins
module sdram_link_asserts (
	input wire logic                         ref_clk,
	input wire logic                         rst_n,
	input wire logic                         cs_n,
	input wire logic                         ras_n,
	input wire logic                         cas_n,
	input wire logic                         we_n,
	input wire logic [sdram_pkg::BANK_W-1:0] ba,
	input wire logic [sdram_pkg::ADDR_W-1:0] addr,
	input wire logic [sdram_pkg::MASK_W-1:0] dqm,
	input wire logic [sdram_pkg::DATA_W-1:0] ctl_dq_o,
	input wire logic                         ctl_dq_oe,
	input wire logic [sdram_pkg::MASK_W-1:0] mem_dq_oe,
	input wire logic [sdram_pkg::DATA_W-1:0] dq
);
	logic [3:0] cmd;

	// command code as the memory samples it
	assign cmd = {cs_n, ras_n, cas_n, we_n};

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// steps of an access
	sequence rd_cmd;
		cmd == sdram_pkg::CMD_RD;
	endsequence
	sequence wr_cmd;
		cmd == sdram_pkg::CMD_WR;
	endsequence

	chk_read_lanes: assert property (rd_cmd |-> ##2 mem_dq_oe == ~$past(dqm, 2) ##1 mem_dq_oe == 4'h0)
		else $error("read lanes driven wrongly");
	chk_drive_cause: assert property (mem_dq_oe != 4'h0 |-> $past(cmd, 2) == sdram_pkg::CMD_RD)
		else $error("memory drives without a read");
	chk_access_opened: assert property ((rd_cmd or wr_cmd) |-> $past(cmd) == sdram_pkg::CMD_ROW_OPEN && $stable(ba))
		else $error("access without row open");
	chk_write_close: assert property (wr_cmd |=> cmd == sdram_pkg::CMD_PRE && $stable(ba))
		else $error("write not closed by precharge");
	chk_read_close: assert property (rd_cmd |=> (cmd == sdram_pkg::CMD_NOP)[*3] ##1 cmd == sdram_pkg::CMD_PRE)
		else $error("read not closed by precharge");
	chk_write_drive: assert property (ctl_dq_oe == (cmd == sdram_pkg::CMD_WR))
		else $error("write data drive mistimed");
	chk_write_bus: assert property (wr_cmd |-> dq == ctl_dq_o && mem_dq_oe == 4'h0)
		else $error("write data not on bus");
	chk_pre_mask: assert property (cmd == sdram_pkg::CMD_PRE |-> dqm == sdram_pkg::DQM_RST && !addr[sdram_pkg::AP_BIT])
		else $error("precharge fields wrong");
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
// controller and memory joined, plus a memory driven directly
module tb;
	logic        ref_clk    = 1'b0;
	logic        rst_n      = 1'b0;
	logic        req_valid  = 1'b0;
	logic        req_write  = 1'b0;
	logic [1:0]  req_bank   = 2'h0;
	logic [10:0] req_row    = 11'h000;
	logic [7:0]  req_col    = 8'h00;
	logic [31:0] req_data   = 32'h0;
	logic [3:0]  req_mask   = 4'h0;
	logic        rd_ready   = 1'b0;
	logic        req_ready;
	logic        rd_valid;
	logic [31:0] rd_data;
	logic [3:0]  bank_open2;
	logic        cmd_error2;
	logic        busy;
	logic        wr_strobe1;
	logic        rd_strobe1;
	logic        cmd_error1;
	int          n_wr = 0;
	int          n_rd = 0;
	int          wr_seen = 0;
	int          rd_seen = 0;
	int          mismatches = 0;
	int          comparisons = 0;
	logic [31:0] mem_m[int];
	logic [31:0] exp_q[$];
	logic [1:0]  b;
	logic [7:0]  c;

	sdram_if lnk (.ref_clk(ref_clk));
	sdram_if drv (.ref_clk(ref_clk));

	sdram_ctl sdram_ctl_i (.ref_clk, .rst_n, .bus(lnk), .req_valid, .req_ready, .req_write,
		.req_bank, .req_row, .req_col, .req_data, .req_mask, .rd_valid, .rd_ready, .rd_data,
		.busy(busy));
	sdram_dev sdram_dev_i (.ref_clk, .rst_n, .bus(lnk), .bank_open(), .wr_strobe(wr_strobe1),
		.rd_strobe(rd_strobe1), .cmd_error(cmd_error1));
	sdram_dev sdram_dev_i2 (.ref_clk, .rst_n, .bus(drv), .bank_open(bank_open2), .wr_strobe(),
		.rd_strobe(), .cmd_error(cmd_error2));
	sdram_link_asserts sdram_link_asserts_i (.ref_clk, .rst_n, .cs_n(lnk.cs_n),
		.ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr),
		.dqm(lnk.dqm), .ctl_dq_o(lnk.ctl_dq_o), .ctl_dq_oe(lnk.ctl_dq_oe),
		.mem_dq_oe(lnk.mem_dq_oe), .dq(lnk.dq));

	// clock
	always #5 ref_clk = ~ref_clk;

	function automatic logic [31:0] lane(logic [3:0] m);
		return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction

	task automatic cmp_word(logic [31:0] got, logic [31:0] exp, string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_flag(logic [3:0] got, logic [3:0] exp, string what);
		cmp_word({28'h0, got}, {28'h0, exp}, what);
	endtask

	// one user request, held until taken, model updated at the accept edge
	task automatic req(logic w, logic [1:0] bk, logic [31:0] d, logic [3:0] m, logic [7:0] cl);
		int n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_bank  <= bk;
		req_row   <= 11'($urandom);
		req_col   <= cl;
		req_data  <= d;
		req_mask  <= m;
		do begin
			@(negedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		if (req_ready !== 1'b1) begin
			mismatches++;
			$display("MISMATCH at %0t: request never taken", $time);
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		if (w) begin
			n_wr++;
			mem_m[{bk, cl}] = (mem_m[{bk, cl}] & lane(m)) | (d & ~lane(m));
		end else begin
			n_rd++;
			exp_q.push_back(mem_m[{bk, cl}] & ~lane(m));
		end
		@(negedge ref_clk);
		cmp_flag({3'h0, busy}, 4'h1, "busy after accept");
	endtask

	// link-side memory status, watched at every falling edge
	always @(negedge ref_clk) begin
		if (rst_n) begin
			if (wr_strobe1 === 1'b1) wr_seen++;
			if (rd_strobe1 === 1'b1) rd_seen++;
			cmp_flag({3'h0, cmd_error1}, 4'h0, "link command error");
		end
	end

	// take one returned word and compare it
	task automatic pop();
		int n = 0;
		@(posedge ref_clk);
		rd_ready <= 1'b1;
		do begin
			@(negedge ref_clk);
			n++;
		end while (rd_valid !== 1'b1 && n < 40);
		if (rd_valid !== 1'b1) begin
			mismatches++;
			$display("MISMATCH at %0t: read word never returned", $time);
		end
		cmp_word(rd_data, exp_q.pop_front(), "read word");
		@(posedge ref_clk);
		rd_ready <= 1'b0;
	endtask

	// direct pins of the second memory
	task automatic cmd2(logic [3:0] cd, logic [1:0] bk, logic [10:0] a);
		@(posedge ref_clk);
		{drv.cs_n, drv.ras_n, drv.cas_n, drv.we_n} <= cd;
		drv.ba   <= bk;
		drv.addr <= a;
	endtask

	task automatic chk2(logic [3:0] o, logic e);
		cmd2(sdram_pkg::CMD_NOP, 2'h0, 11'h0);
		@(negedge ref_clk);
		cmp_flag(bank_open2, o, "banks open");
		cmp_flag({3'h0, cmd_error2}, {3'h0, e}, "command error");
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end

	// main sequence
	initial begin
		{drv.cs_n, drv.ras_n, drv.cas_n, drv.we_n} = 4'hF;
		drv.ba = 2'h0;
		drv.addr = 11'h0;
		drv.dqm = 4'hF;
		drv.ctl_dq_o = 32'h0;
		drv.ctl_dq_oe = 1'b0;
		void'($urandom(82));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			b = 2'(i);
			c = 8'($urandom);
			req(1'b1, b, $urandom, 4'h0, c);
			req(1'b1, b, $urandom, 4'(i), c);
			req(1'b0, b, 32'h0, 4'h0, c);
			pop();
			req(1'b0, b, 32'h0, 4'(i), c);
			pop();
		end
		$display("test byte masks done");
		repeat (4) req(1'b0, b, 32'h0, 4'($urandom), c);
		repeat (10) @(posedge ref_clk);
		fork
			req(1'b0, b, 32'h0, 4'h5, c);
			begin
				repeat (6) begin
					@(negedge ref_clk);
					cmp_flag({3'h0, req_ready}, 4'h0, "ready with full fifo");
				end
				repeat (5) pop();
			end
		join
		$display("test fifo full done");
		for (int i = 8; i < 16; i++) begin
			cmd2(4'(i), 2'(i), 11'h0);
			chk2(4'h0, 1'b0);
		end
		cmd2(sdram_pkg::CMD_RD, 2'h1, 11'h0);
		chk2(4'h0, 1'b1);
		cmd2(sdram_pkg::CMD_ROW_OPEN, 2'h2, 11'($urandom));
		chk2(4'h4, 1'b0);
		cmd2(sdram_pkg::CMD_ROW_OPEN, 2'h2, 11'h0);
		chk2(4'h4, 1'b1);
		cmd2(sdram_pkg::CMD_PRE, 2'h2, 11'h0);
		cmd2(sdram_pkg::CMD_ROW_OPEN, 2'h2, 11'h0);
		cmd2(sdram_pkg::CMD_NOP, 2'h0, 11'h0);
		@(negedge ref_clk);
		cmp_flag(bank_open2, 4'h0, "open while precharging");
		repeat (3) cmd2(sdram_pkg::CMD_NOP, 2'h0, 11'h0);
		cmd2(sdram_pkg::CMD_ROW_OPEN, 2'h0, 11'h0);
		cmd2(sdram_pkg::CMD_ROW_OPEN, 2'h3, 11'h0);
		chk2(4'h9, 1'b0);
		cmd2(sdram_pkg::CMD_PRE, 2'h0, 11'h400);
		repeat (3) cmd2(sdram_pkg::CMD_NOP, 2'h0, 11'h0);
		chk2(4'h0, 1'b0);
		$display("test direct commands done");
		cmp_word(32'(wr_seen), 32'(n_wr), "write strobes");
		cmp_word(32'(rd_seen), 32'(n_rd), "read strobes");
		give_verdict();
	end
endmodule

// [verilog/sdram_ctl.sv]
`timescale 1ns/1ps
// small synchronous fifo, valid and ready on both sides
module sync_fifo #(
	parameter int WIDTH = sdram_pkg::DATA_W,
	parameter int DEPTH = sdram_pkg::FIFO_DEPTH
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] buf_q [DEPTH];
	logic [PW-1:0]    wp_q;
	logic [PW-1:0]    wp_d;
	logic [PW-1:0]    rp_q;
	logic [PW-1:0]    rp_d;
	logic [PW:0]      cnt_q;
	logic [PW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = buf_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer and count update
	always_comb begin
		wp_d  = push ? ((wp_q == PW'(DEPTH-1)) ? '0 : wp_q + PW'(1)) : wp_q;
		rp_d  = pop ? ((rp_q == PW'(DEPTH-1)) ? '0 : rp_q + PW'(1)) : rp_q;
		cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
	end

	// registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			buf_q[wp_q] <= in_data;
		end
	end
endmodule

// controller end: one open-access-close sequence per request
module sdram_ctl (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	sdram_if.ctl                               bus,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire logic                          req_write,
	input  wire logic [sdram_pkg::BANK_W-1:0]  req_bank,
	input  wire logic [sdram_pkg::ADDR_W-1:0]  req_row,
	input  wire logic [sdram_pkg::COL_W-1:0]   req_col,
	input  wire logic [sdram_pkg::DATA_W-1:0]  req_data,
	input  wire logic [sdram_pkg::MASK_W-1:0]  req_mask,
	output logic                               rd_valid,
	input  wire logic                          rd_ready,
	output logic [sdram_pkg::DATA_W-1:0]       rd_data,
	output logic                               busy
);
	localparam int CW = sdram_pkg::CNT_W;

	sdram_pkg::ctl_state_t        state_q;
	sdram_pkg::ctl_state_t        state_d;
	logic [3:0]                   cmd_q;
	logic [3:0]                   cmd_d;
	logic [sdram_pkg::BANK_W-1:0] ba_q;
	logic [sdram_pkg::BANK_W-1:0] ba_d;
	logic [sdram_pkg::ADDR_W-1:0] addr_q;
	logic [sdram_pkg::ADDR_W-1:0] addr_d;
	logic [sdram_pkg::MASK_W-1:0] dqm_q;
	logic [sdram_pkg::MASK_W-1:0] dqm_d;
	logic [sdram_pkg::DATA_W-1:0] dq_q;
	logic [sdram_pkg::DATA_W-1:0] dq_d;
	logic                         oe_q;
	logic                         oe_d;
	logic [CW-1:0]                cnt_q;
	logic [CW-1:0]                cnt_d;
	logic                         wr_q;
	logic                         wr_d;
	logic [sdram_pkg::COL_W-1:0]  col_q;
	logic [sdram_pkg::COL_W-1:0]  col_d;
	logic                         fifo_ready;
	logic                         push;

	// a read waits for fifo room so its word always fits
	assign req_ready = (state_q == sdram_pkg::S_IDLE) & (req_write | fifo_ready);
	assign push      = (state_q == sdram_pkg::S_RDW) & (cnt_q == CW'(sdram_pkg::READ_LAT));
	assign busy      = (state_q != sdram_pkg::S_IDLE);

	// sequence: open row, column access, optional read wait, close bank
	always_comb begin
		state_d = state_q;
		cmd_d   = sdram_pkg::CMD_NOP;
		ba_d    = ba_q;
		addr_d  = addr_q;
		dqm_d   = dqm_q;
		dq_d    = dq_q;
		oe_d    = 1'b0;
		cnt_d   = cnt_q;
		wr_d    = wr_q;
		col_d   = col_q;
		unique case (state_q)
			sdram_pkg::S_IDLE: begin
				if (req_valid && req_ready) begin
					cmd_d   = sdram_pkg::CMD_ROW_OPEN;
					ba_d    = req_bank;
					addr_d  = req_row;
					wr_d    = req_write;
					col_d   = req_col;
					dqm_d   = req_mask;
					dq_d    = req_data;
					state_d = sdram_pkg::S_OPEN;
				end
			end
			sdram_pkg::S_OPEN: begin
				cmd_d   = wr_q ? sdram_pkg::CMD_WR : sdram_pkg::CMD_RD;
				addr_d  = sdram_pkg::ADDR_W'(col_q);
				oe_d    = wr_q;
				cnt_d   = '0;
				state_d = wr_q ? sdram_pkg::S_PRE : sdram_pkg::S_RDW;
			end
			sdram_pkg::S_RDW: begin
				if (push) begin
					state_d = sdram_pkg::S_PRE;
				end else begin
					cnt_d = cnt_q + CW'(1);
				end
			end
			sdram_pkg::S_PRE: begin
				cmd_d   = sdram_pkg::CMD_PRE;
				addr_d  = '0;
				dqm_d   = sdram_pkg::DQM_RST;
				cnt_d   = CW'(sdram_pkg::PRE_CYC - 1);
				state_d = sdram_pkg::S_PREW;
			end
			sdram_pkg::S_PREW: begin
				if (cnt_q == '0) begin
					state_d = sdram_pkg::S_IDLE;
				end else begin
					cnt_d = cnt_q - CW'(1);
				end
			end
			default: begin
				state_d = sdram_pkg::S_IDLE;
			end
		endcase
	end

	// pins launched from flops on the rising edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= sdram_pkg::S_IDLE;
			cmd_q   <= sdram_pkg::CMD_DESEL;
			ba_q    <= '0;
			addr_q  <= '0;
			dqm_q   <= sdram_pkg::DQM_RST;
			dq_q    <= '0;
			oe_q    <= 1'b0;
			cnt_q   <= '0;
			wr_q    <= 1'b0;
			col_q   <= '0;
		end else begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
			ba_q    <= ba_d;
			addr_q  <= addr_d;
			dqm_q   <= dqm_d;
			dq_q    <= dq_d;
			oe_q    <= oe_d;
			cnt_q   <= cnt_d;
			wr_q    <= wr_d;
			col_q   <= col_d;
		end
	end

	assign bus.cs_n      = cmd_q[3];
	assign bus.ras_n     = cmd_q[2];
	assign bus.cas_n     = cmd_q[1];
	assign bus.we_n      = cmd_q[0];
	assign bus.ba        = ba_q;
	assign bus.addr      = addr_q;
	assign bus.dqm       = dqm_q;
	assign bus.ctl_dq_o  = dq_q;
	assign bus.ctl_dq_oe = oe_q;

	// read words buffered toward the user
	sync_fifo #(
		.WIDTH (sdram_pkg::DATA_W),
		.DEPTH (sdram_pkg::FIFO_DEPTH)
	) u_rd_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (bus.dq),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);
endmodule

// [verilog/sdram_dev.sv]
`timescale 1ns/1ps
// memory end: command decode, bank states, masked storage
module sdram_dev #(
	parameter int COL_BITS = sdram_pkg::COL_W,
	parameter int RD_LAT   = sdram_pkg::READ_LAT
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	sdram_if.mem                               bus,
	output logic [sdram_pkg::BANKS-1:0]        bank_open,
	output logic                               wr_strobe,
	output logic                               rd_strobe,
	output logic                               cmd_error
);
	localparam int CW = sdram_pkg::CNT_W;
	localparam int AW = sdram_pkg::BANK_W + COL_BITS;
	localparam int BW = sdram_pkg::BYTE_W;

	logic [3:0]                   cmd;
	logic                         is_open;
	logic                         is_pre;
	logic                         is_rd;
	logic                         is_wr;
	logic                         hit_active;
	logic                         wr_en;
	logic                         rd_en;
	logic [AW-1:0]                idx;
	logic [sdram_pkg::BANKS-1:0]  bank_idle;
	logic [sdram_pkg::DATA_W-1:0] mem_q [2**AW];
	logic [sdram_pkg::DATA_W-1:0] rd_data_q [RD_LAT];
	logic [sdram_pkg::DATA_W-1:0] rd_data_d [RD_LAT];
	logic [sdram_pkg::MASK_W-1:0] rd_mask_q [RD_LAT];
	logic [sdram_pkg::MASK_W-1:0] rd_mask_d [RD_LAT];
	logic [RD_LAT-1:0]            rd_vld_q;
	logic [RD_LAT-1:0]            rd_vld_d;
	logic                         wr_strobe_d;
	logic                         rd_strobe_d;
	logic                         cmd_error_d;

	// pins taken as one code, cs_n high matches no code
	assign cmd     = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
	assign is_open = (cmd == sdram_pkg::CMD_ROW_OPEN);
	assign is_pre  = (cmd == sdram_pkg::CMD_PRE);
	assign is_rd   = (cmd == sdram_pkg::CMD_RD);
	assign is_wr   = (cmd == sdram_pkg::CMD_WR);

	// column access acts only on an open bank
	assign idx        = {bus.ba, bus.addr[COL_BITS-1:0]};
	assign hit_active = bank_open[bus.ba];
	assign wr_en      = is_wr & hit_active;
	assign rd_en      = is_rd & hit_active;

	// per-bank state machine
	for (genvar b = 0; b < sdram_pkg::BANKS; b++) begin : g_bank
		sdram_pkg::bank_state_t st_q;
		sdram_pkg::bank_state_t st_d;
		logic [CW-1:0]          cnt_q;
		logic [CW-1:0]          cnt_d;
		logic                   hit;
		logic                   close_req;

		assign hit       = (bus.ba == sdram_pkg::BANK_W'(b));
		assign close_req = is_pre & (hit | bus.addr[sdram_pkg::AP_BIT]);

		// next state of one bank
		always_comb begin
			st_d  = st_q;
			cnt_d = cnt_q;
			unique case (st_q)
				sdram_pkg::B_IDLE: begin
					if (is_open && hit) begin
						st_d = sdram_pkg::B_ACTIVE;
					end
				end
				sdram_pkg::B_ACTIVE: begin
					if (close_req) begin
						st_d  = sdram_pkg::B_PRECH;
						cnt_d = CW'(sdram_pkg::PRE_CYC - 1);
					end
				end
				sdram_pkg::B_PRECH: begin
					if (cnt_q == '0) begin
						st_d = sdram_pkg::B_IDLE;
					end else begin
						cnt_d = cnt_q - CW'(1);
					end
				end
				default: begin
					st_d = sdram_pkg::B_IDLE;
				end
			endcase
		end

		// bank state registers
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				st_q  <= sdram_pkg::B_IDLE;
				cnt_q <= '0;
			end else begin
				st_q  <= st_d;
				cnt_q <= cnt_d;
			end
		end

		assign bank_open[b] = (st_q == sdram_pkg::B_ACTIVE);
		assign bank_idle[b] = (st_q == sdram_pkg::B_IDLE);
	end

	// masked byte writes into storage
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < sdram_pkg::MASK_W; i++) begin
			if (wr_en && !bus.dqm[i]) begin
				mem_q[idx][i*BW +: BW] <= bus.dq[i*BW +: BW];
			end
		end
	end

	// read pipeline with mask carried alongside the data
	always_comb begin
		rd_data_d[0] = mem_q[idx];
		rd_mask_d[0] = bus.dqm;
		rd_vld_d[0]  = rd_en;
		for (int s = 1; s < RD_LAT; s++) begin
			rd_data_d[s] = rd_data_q[s-1];
			rd_mask_d[s] = rd_mask_q[s-1];
			rd_vld_d[s]  = rd_vld_q[s-1];
		end
	end

	// read pipeline registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_vld_q <= '0;
			for (int s = 0; s < RD_LAT; s++) begin
				rd_data_q[s] <= '0;
				rd_mask_q[s] <= sdram_pkg::DQM_RST;
			end
		end else begin
			rd_vld_q <= rd_vld_d;
			for (int s = 0; s < RD_LAT; s++) begin
				rd_data_q[s] <= rd_data_d[s];
				rd_mask_q[s] <= rd_mask_d[s];
			end
		end
	end

	// read data launched from the last stage, masked lanes left undriven
	assign bus.mem_dq_o  = rd_data_q[RD_LAT-1];
	assign bus.mem_dq_oe = {sdram_pkg::MASK_W{rd_vld_q[RD_LAT-1]}}
		& ~rd_mask_q[RD_LAT-1];

	// status pulses, error on a command to a bank in the wrong state
	always_comb begin
		wr_strobe_d = wr_en;
		rd_strobe_d = rd_en;
		cmd_error_d = ((is_rd | is_wr) & ~hit_active)
			| (is_open & ~bank_idle[bus.ba]);
	end

	// status registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			cmd_error <= 1'b0;
		end else begin
			wr_strobe <= wr_strobe_d;
			rd_strobe <= rd_strobe_d;
			cmd_error <= cmd_error_d;
		end
	end
endmodule

// [verilog/sdram_if.sv]
`timescale 1ns/1ps
// pin bundle between controller and memory
interface sdram_if (
	input wire logic ref_clk
);
	logic                         cs_n;
	logic                         ras_n;
	logic                         cas_n;
	logic                         we_n;
	logic [sdram_pkg::BANK_W-1:0] ba;
	logic [sdram_pkg::ADDR_W-1:0] addr;
	logic [sdram_pkg::MASK_W-1:0] dqm;
	logic [sdram_pkg::DATA_W-1:0] ctl_dq_o;
	logic                         ctl_dq_oe;
	logic [sdram_pkg::DATA_W-1:0] mem_dq_o;
	logic [sdram_pkg::MASK_W-1:0] mem_dq_oe;
	logic [sdram_pkg::DATA_W-1:0] dq;

	// resolved bus level per byte, undriven reads zero
	for (genvar i = 0; i < sdram_pkg::MASK_W; i++) begin : g_lane
		assign dq[i*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W] =
			ctl_dq_oe ? ctl_dq_o[i*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W] :
			mem_dq_oe[i] ? mem_dq_o[i*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W] :
			8'h00;
	end

	modport ctl (
		input  ref_clk,
		output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_o, ctl_dq_oe,
		input  dq
	);
	modport mem (
		input  ref_clk, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output mem_dq_o, mem_dq_oe
	);
endinterface

// [verilog/sdram_pkg.sv]
package sdram_pkg;
	localparam int DATA_W   = 32;
	localparam int MASK_W   = 4;
	localparam int BYTE_W   = 8;
	localparam int BANKS    = 4;
	localparam int BANK_W   = 2;
	localparam int ADDR_W   = 11;
	localparam int COL_W    = 8;
	localparam int AP_BIT   = 10;
	localparam int CNT_W    = 4;
	localparam int FIFO_DEPTH = 4;

	// command code {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_ROW_OPEN = 4'h3;
	localparam logic [3:0] CMD_PRE      = 4'h2;
	localparam logic [3:0] CMD_RD       = 4'h5;
	localparam logic [3:0] CMD_WR       = 4'h4;
	localparam logic [3:0] CMD_NOP      = 4'h7;
	localparam logic [3:0] CMD_DESEL    = 4'hF;
	localparam logic [3:0] DQM_RST      = 4'hF;

	// timing
	localparam int CLK_NS       = 10;
	localparam int PRECHARGE_NS = 20;
	localparam int PRE_CYC      = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_LAT     = 2;

	typedef enum logic [2:0] {
		B_IDLE   = 3'h1,
		B_ACTIVE = 3'h2,
		B_PRECH  = 3'h4
	} bank_state_t;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_OPEN = 6'h02,
		S_RDW  = 6'h04,
		S_PRE  = 6'h08,
		S_PREW = 6'h10
	} ctl_state_t;
endpackage
